// >>> rtl/fic_top.sv
// Fault and interrupt input capture with operand bus release and an AXI4-Lite register slave.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "fic_consts.svh"
module fic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic system_fault_in,
  input wire logic bus_timeout_error_n,
  input wire logic memory_parity_error_in,
  input wire logic memory_protect_fault_in,
  input wire logic io_cycle_in,
  input wire logic mem_cycle_in,
  input wire logic user_irq0_n,
  input wire logic user_irq1_n,
  input wire logic user_irq2_n,
  input wire logic user_irq3_n,
  input wire logic user_irq4_n,
  input wire logic user_irq5_n,
  input wire logic io_level_irq0_n,
  input wire logic io_level_irq1_n,
  input wire logic power_fail_n,
  input wire logic master_reset_n,
  input wire logic test_mode_n,
  input wire logic bus_owned_in,
  input wire logic core_write_in,
  input wire logic [15:0] core_addr_in,
  input wire logic [15:0] core_wdata_in,
  output logic [15:0] core_rdata,
  output logic [15:0] oper_addr_o,
  output logic oper_addr_oe_n,
  input wire logic [15:0] oper_data_i,
  output logic [15:0] oper_data_o,
  output logic oper_data_oe_n,
  output logic irq
);

  fic_pkg::fic_state_s s_r;
  fic_pkg::fic_state_s s_nxt;

  logic [7:0] irq_n_vec;
  logic [7:0] irq_fall;
  logic sys_rise;
  logic [15:0] fset;
  logic [15:0] fhold;
  logic [15:0] fclr;
  logic [15:0] pset;
  logic [15:0] pclr;
  logic [15:0] wmask;
  logic [15:0] wbits;
  logic [15:0] rword;
  logic [15:0] pins;
  logic wr_fire;
  logic drive_ok;

  assign irq_n_vec = {io_level_irq1_n, io_level_irq0_n, user_irq5_n, user_irq4_n,
                      user_irq3_n, user_irq2_n, user_irq1_n, user_irq0_n};

  // User and I/O level interrupt inputs are all active low and edge sensitive.
  for (genvar gi = 0; gi < 8; gi++) begin : g_irq_edge
    fic_edge #(
      .ACTIVE_HIGH(1'h0)
    ) u_irq_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(irq_n_vec[gi]),
      .edge_pulse(irq_fall[gi])
    );
  end

  fic_edge #(
    .ACTIVE_HIGH(1'h1)
  ) u_sys_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_in(system_fault_in),
    .edge_pulse(sys_rise)
  );

  assign pins = {~irq_n_vec, !test_mode_n, bus_owned_in, !master_reset_n, !power_fail_n,
                 memory_protect_fault_in, memory_parity_error_in, !bus_timeout_error_n,
                 system_fault_in};

  always_comb begin
    s_nxt = s_r;
    fset = `FIC_RST_WORD;
    fhold = `FIC_RST_WORD;
    pset = `FIC_RST_WORD;
    fclr = `FIC_RST_WORD;
    pclr = `FIC_RST_WORD;
    rword = `FIC_RST_WORD;

    fset[`FIC_FLT_SYS] = sys_rise; // see [R01]
    if (!bus_timeout_error_n) begin
      fset[`FIC_FLT_IO_TMO] = io_cycle_in; // see [R02]
      fset[`FIC_FLT_MEM_TMO] = mem_cycle_in; // see [R02]
    end
    fset[`FIC_FLT_PARITY] = memory_parity_error_in; // see [R03]
    if (memory_protect_fault_in) begin
      if (bus_owned_in) begin
        fset[`FIC_FLT_CPU] = 1'h1; // see [R04]
      end else begin
        fset[`FIC_FLT_DMA] = 1'h1; // see [R05]
      end
    end

    // A timeout, parity or protect fault bit whose input is still asserted cannot be cleared by software.
    fhold[`FIC_FLT_IO_TMO] = !bus_timeout_error_n; // see [R07]
    fhold[`FIC_FLT_MEM_TMO] = !bus_timeout_error_n; // see [R07]
    fhold[`FIC_FLT_PARITY] = memory_parity_error_in; // see [R07]
    fhold[`FIC_FLT_DMA] = memory_protect_fault_in; // see [R07]
    fhold[`FIC_FLT_CPU] = memory_protect_fault_in; // see [R07]

    pset[7:0] = irq_fall; // see [R08] [R09]
    pset[`FIC_PEND_POWER_FAIL_N] = !power_fail_n; // see [R12]

    // Write channel: address and data are taken in either order, then answered.
    wr_fire = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    wmask = {{8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
    wbits = s_r.wdata[15:0] & wmask;
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'h1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'h1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'h0;
    end
    if (wr_fire) begin
      s_nxt.aw_have = 1'h0;
      s_nxt.w_have = 1'h0;
      s_nxt.bvalid = 1'h1;
      s_nxt.bresp = `FIC_RESP_OKAY;
      case (s_r.aw_addr)
        `FIC_OFS_FAULT: begin
          fclr = wbits & ~fhold; // see [R07]
        end
        `FIC_OFS_FMASK: begin
          s_nxt.fmask = ((s_r.fmask & ~wmask) | wbits) & `FIC_FLT_IMPL;
        end
        `FIC_OFS_PEND: begin
          pclr = wbits;
        end
        `FIC_OFS_IMASK: begin
          // The power fail position is not writable, so it can never be masked.
          s_nxt.imask = ((s_r.imask & ~wmask) | wbits) & `FIC_IMASK_WR; // see [R10] [R13]
        end
        `FIC_OFS_PINS, `FIC_OFS_DATA_IN: begin
          s_nxt.bresp = `FIC_RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = `FIC_RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

    // Sticky bits: a set in the same cycle as a clear wins.
    s_nxt.fault = ((s_r.fault & ~fclr) | fset) & `FIC_FLT_IMPL; // see [R19]
    s_nxt.pend = ((s_r.pend & ~pclr) | pset) & `FIC_PEND_IMPL; // see [R19]
    // Master reset empties both registers for as long as it is held, even over a new event.
    if (!master_reset_n) begin
      s_nxt.fault = `FIC_RST_WORD; // see [R19]
      s_nxt.pend = `FIC_RST_WORD; // see [R11]
    end

    // Read channel: one read at a time, answered in the cycle after the address is taken.
    unique case (s_r.rd)
      fic_pkg::FIC_RD_IDLE: begin
        if (s_axi_arvalid && s_r.arready) begin
          s_nxt.rd = fic_pkg::FIC_RD_RESP;
          s_nxt.rvalid = 1'h1;
          s_nxt.rresp = `FIC_RESP_OKAY;
          case (s_axi_araddr)
            `FIC_OFS_FAULT: rword = s_r.fault;
            `FIC_OFS_FMASK: rword = s_r.fmask;
            `FIC_OFS_PEND: rword = s_r.pend;
            `FIC_OFS_IMASK: rword = s_r.imask;
            `FIC_OFS_PINS: rword = pins;
            `FIC_OFS_DATA_IN: rword = s_r.data_seen;
            default: s_nxt.rresp = `FIC_RESP_SLVERR;
          endcase
          s_nxt.rdata = {16'h0000, rword};
        end
      end
      fic_pkg::FIC_RD_RESP: begin
        if (s_axi_rready) begin
          s_nxt.rd = fic_pkg::FIC_RD_IDLE;
          s_nxt.rvalid = 1'h0;
        end
      end
    endcase
    s_nxt.arready = (s_nxt.rd == fic_pkg::FIC_RD_IDLE);

    // Power fail bypasses the mask entirely.
    s_nxt.irq = (|(s_nxt.fault & ~s_nxt.fmask)) ||
                (|(s_nxt.pend[7:0] & ~s_nxt.imask[7:0])) ||
                s_nxt.pend[`FIC_PEND_POWER_FAIL_N]; // see [R10] [R12] [R13]

    // Operand address pins are released unless we own the bus and test mode is off; data pins also need a core write.
    drive_ok = bus_owned_in && test_mode_n; // see [R18]
    s_nxt.addr_o = core_addr_in;
    s_nxt.addr_oe_n = !drive_ok; // see [R16]
    s_nxt.data_o = core_wdata_in;
    s_nxt.data_oe_n = !(drive_ok && core_write_in); // see [R17]
    if (s_r.data_oe_n) begin
      s_nxt.data_seen = oper_data_i;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.addr_oe_n <= 1'h1;
      s_r.data_oe_n <= 1'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign irq = s_r.irq;
  assign oper_addr_o = s_r.addr_o;
  assign oper_addr_oe_n = s_r.addr_oe_n;
  assign oper_data_o = s_r.data_o;
  assign oper_data_oe_n = s_r.data_oe_n;
  assign core_rdata = s_r.data_seen;

  a_sys_fault_set: assert property (@(posedge aclk) disable iff (!aresetn) // see [R01]
    (system_fault_in && !$past(system_fault_in) && master_reset_n) |=> s_r.fault[8])
    else $error("system fault edge did not set fault bit 8");

  a_timeout_io_mem: assert property (@(posedge aclk) disable iff (!aresetn) // see [R02]
    (!bus_timeout_error_n && master_reset_n) |=>
      ((s_r.fault[10] == $past(io_cycle_in)) || $past(s_r.fault[10])) &&
      (s_r.fault[7] || !$past(mem_cycle_in)))
    else $error("bus timeout did not set the bit of its cycle type");

  a_parity_set: assert property (@(posedge aclk) disable iff (!aresetn) // see [R03]
    (memory_parity_error_in && master_reset_n) |=> s_r.fault[13])
    else $error("parity error did not set fault bit 13");

  a_protect_cpu: assert property (@(posedge aclk) disable iff (!aresetn) // see [R04]
    (memory_protect_fault_in && bus_owned_in && master_reset_n) |=> s_r.fault[15])
    else $error("protect fault on owned bus did not set bit 15");

  a_protect_dma: assert property (@(posedge aclk) disable iff (!aresetn) // see [R05]
    (memory_protect_fault_in && !bus_owned_in && master_reset_n) |=> s_r.fault[14])
    else $error("protect fault on foreign bus did not set bit 14");

  a_clear_blocked: assert property (@(posedge aclk) disable iff (!aresetn) // see [R07]
    (s_r.fault[7] && !bus_timeout_error_n && master_reset_n) |=> s_r.fault[7])
    else $error("timeout fault cleared while its input was asserted");

  a_irq_edge_pend: assert property (@(posedge aclk) disable iff (!aresetn) // see [R08] [R09]
    (irq_fall != 8'h00 && master_reset_n) |=> ((s_r.pend[7:0] & $past(irq_fall)) == $past(irq_fall)))
    else $error("interrupt falling edge did not set its pending bit");

  a_mask_gates: assert property (@(posedge aclk) disable iff (!aresetn) // see [R10]
    ((s_r.fault & ~s_r.fmask) == 16'h0000 && s_r.pend[15] == 1'h0 &&
     (s_r.pend[7:0] & ~s_r.imask[7:0]) == 8'h00) |-> !irq)
    else $error("interrupt raised with every source masked");

  a_master_reset_n_clears: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
    !master_reset_n |=> (s_r.pend == 16'h0000 && s_r.fault == 16'h0000))
    else $error("master reset left pending or fault bits set");

  a_power_fail_n_irq: assert property (@(posedge aclk) disable iff (!aresetn) // see [R12] [R13]
    (!power_fail_n && master_reset_n) |=> (s_r.pend[15] && irq && !s_r.imask[15]))
    else $error("power fail did not raise an unmaskable interrupt");

  a_addr_release: assert property (@(posedge aclk) disable iff (!aresetn) // see [R16]
    !bus_owned_in |=> (oper_addr_oe_n && oper_data_oe_n))
    else $error("operand bus driven while not owned");

  a_test_release: assert property (@(posedge aclk) disable iff (!aresetn) // see [R17] [R18]
    !test_mode_n |=> (oper_addr_oe_n && oper_data_oe_n))
    else $error("operand bus driven in test mode");

  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // see [R19]
    (s_r.fault[8] && master_reset_n && !fclr[8]) |=> s_r.fault[8])
    else $error("system fault bit dropped without a clear");

endmodule : fic_top

// >>> rtl/fic_consts.svh
// Register map, field positions and reset values of the fault and interrupt capture block.
// Functional notes
// [R01] A rising edge on system fault sets fault bit 8.
// [R02] Bus timeout sets fault bit 10 in I/O cycles, bit 7 in memory cycles.
// [R03] Memory parity error input sets fault bit 13 while asserted.
// [R04] Memory protect fault while we own the operand bus sets fault bit 15.
// [R05] Memory protect fault while we do not own the bus sets fault bit 14.
// [R06] External memory management raises memory protect on access, write or execute faults.
// [R07] Software clear of timeout, parity or protect faults ignored while input still asserted.
// [R08] Falling edge on a user interrupt input sets its pending bit.
// [R09] Falling edge on an I/O level interrupt input sets its pending bit.
// [R10] Software masks each user and I/O level interrupt by setting its mask bit.
// [R11] Master reset clears all pending user and I/O level interrupts.
// [R12] Power fail sets pending bit 15 and interrupts the processor.
// [R13] Nothing can mask or disable the power fail interrupt.
// [R14] In native mode the system applies master reset after any power fail.
// [R15] The system holds master reset low for at least one clock period.
// [R16] Operand address bus is driven only while we own the bus.
// [R17] Operand data bus is bidirectional and released when we do not own the bus.
// [R18] Test mode releases both operand address and data buses.
// [R19] Fault and pending bits stay set until software clear or master reset.
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH

`define FIC_OFS_FAULT 8'h00
`define FIC_OFS_FMASK 8'h04
`define FIC_OFS_PEND 8'h08
`define FIC_OFS_IMASK 8'h0C
`define FIC_OFS_PINS 8'h10
`define FIC_OFS_DATA_IN 8'h14

`define FIC_FLT_MEM_TMO 4'h7
`define FIC_FLT_SYS 4'h8
`define FIC_FLT_IO_TMO 4'hA
`define FIC_FLT_PARITY 4'hD
`define FIC_FLT_DMA 4'hE
`define FIC_FLT_CPU 4'hF
`define FIC_PEND_POWER_FAIL_N 4'hF

`define FIC_FLT_IMPL 16'hE580
`define FIC_PEND_IMPL 16'h80FF
`define FIC_IMASK_WR 16'h00FF
`define FIC_RST_WORD 16'h0000

`define FIC_RESP_OKAY 2'h0
`define FIC_RESP_SLVERR 2'h2

`endif

// >>> rtl/fic_pkg.sv
// Types shared by the fault and interrupt capture block.
package fic_pkg;

  typedef enum logic {FIC_RD_IDLE, FIC_RD_RESP} fic_rd_e;

  typedef struct packed {
    logic prev;
  } fic_edge_s;

  typedef struct packed {
    logic [15:0] fault;
    logic [15:0] fmask;
    logic [15:0] pend;
    logic [15:0] imask;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    fic_rd_e rd;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic [15:0] addr_o;
    logic addr_oe_n;
    logic [15:0] data_o;
    logic data_oe_n;
    logic [15:0] data_seen;
  } fic_state_s;

endpackage : fic_pkg

// >>> rtl/fic_edge.sv
// Single-input edge detector that pulses for one cycle on the active-going edge.
`timescale 1ns/1ns
module fic_edge #(
  parameter bit ACTIVE_HIGH = 1'h1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level_in,
  output logic edge_pulse
);

  fic_pkg::fic_edge_s s_r;
  fic_pkg::fic_edge_s s_nxt;

  // The history starts at the idle level, so an input already active at reset is seen as an edge.
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = level_in;
    edge_pulse = ACTIVE_HIGH ? (level_in && !s_r.prev) : (!level_in && s_r.prev);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r.prev <= !ACTIVE_HIGH;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : fic_edge

// >>> verif/fic_far.sv
// Far-side model: memory management unit, bus controller and system reset logic.
`timescale 1ns/1ns
module fic_far (
  input wire logic aclk,
  input wire logic [15:0] oper_data_o,
  input wire logic oper_data_oe_n,
  output logic memory_protect_fault_in,
  output logic bus_owned_in,
  output logic io_cycle_in,
  output logic mem_cycle_in,
  output logic master_reset_n,
  output logic [15:0] oper_data_i
);
  logic [15:0] last_r;
  localparam logic [15:0] DMA_WORD = 16'hA55A;
  initial begin
    {memory_protect_fault_in, bus_owned_in, io_cycle_in, mem_cycle_in} = 4'h0;
    master_reset_n = 1'b1;
    last_r = 16'h0000;
  end
  // A bus that nobody drives shows a changing pattern, so a stale value can never pass.
  always_comb begin
    if (oper_data_oe_n == 1'b0) oper_data_i = oper_data_o;
    else if (bus_owned_in == 1'b0) oper_data_i = DMA_WORD;
    else oper_data_i = ~last_r;
  end
  always @(posedge aclk) last_r <= oper_data_i;
  // Access, write-protect and execute-protect faults all raise the same line for n cycles.
  task automatic mmu_fault(input logic [1:0] kind, input int n);
    @(posedge aclk);
    memory_protect_fault_in <= (kind != 2'h3);
    repeat (n) @(posedge aclk);
    memory_protect_fault_in <= 1'b0;
  endtask : mmu_fault
  task automatic own(input logic o);
    @(posedge aclk);
    bus_owned_in <= o;
  endtask : own
  task automatic cycle_kind(input logic io, input logic mem);
    @(posedge aclk);
    io_cycle_in <= io;
    mem_cycle_in <= mem;
  endtask : cycle_kind
  // The pulse never shrinks below one clock, whatever the caller asks.
  task automatic mreset(input int n);
    @(posedge aclk);
    master_reset_n <= 1'b0;
    repeat ((n < 1) ? 1 : n) @(posedge aclk);
    master_reset_n <= 1'b1;
  endtask : mreset
endmodule : fic_far

// >>> verif/fic_top_test.sv
// Self-checking bench for the fault and interrupt capture block.
`timescale 1ns/1ns
`include "fic_consts.svh"
module fic_top_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, irq_n;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic system_fault_in, bus_timeout_error_n, memory_parity_error_in, memory_protect_fault_in;
  logic io_cycle_in, mem_cycle_in, power_fail_n, master_reset_n, test_mode_n, bus_owned_in;
  logic core_write_in, oper_addr_oe_n, oper_data_oe_n, irq;
  logic [15:0] core_addr_in, core_wdata_in, core_rdata, oper_addr_o, oper_data_i, oper_data_o;
  int failures, comparisons, cycles;

  fic_top fic_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .system_fault_in, .bus_timeout_error_n,
    .memory_parity_error_in, .memory_protect_fault_in, .io_cycle_in, .mem_cycle_in,
    .user_irq0_n(irq_n[0]), .user_irq1_n(irq_n[1]), .user_irq2_n(irq_n[2]),
    .user_irq3_n(irq_n[3]), .user_irq4_n(irq_n[4]), .user_irq5_n(irq_n[5]),
    .io_level_irq0_n(irq_n[6]), .io_level_irq1_n(irq_n[7]), .power_fail_n, .master_reset_n,
    .test_mode_n, .bus_owned_in, .core_write_in, .core_addr_in, .core_wdata_in, .core_rdata,
    .oper_addr_o, .oper_addr_oe_n, .oper_data_i, .oper_data_o, .oper_data_oe_n, .irq);
  fic_far fic_far_i (.aclk, .oper_data_o, .oper_data_oe_n, .memory_protect_fault_in,
    .bus_owned_in, .io_cycle_in, .mem_cycle_in, .master_reset_n, .oper_data_i);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // The whole sequence needs well under a thousand cycles.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdata = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk_word(what, exp, rdata);
    chk_word("read response", {30'h0, `FIC_RESP_OKAY}, {30'h0, resp});
  endtask : rchk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
    {system_fault_in, memory_parity_error_in, core_write_in} = 3'h0;
    {bus_timeout_error_n, power_fail_n, test_mode_n, irq_n} = {3'h7, 8'hFF};
    {core_addr_in, core_wdata_in} = {16'h1234, 16'hBEEF};
    {failures, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("fault", `FIC_OFS_FAULT, 32'h0);
    chk_bit("address enable", 1'b1, oper_addr_oe_n);
    wr(`FIC_OFS_FMASK, 32'hFFFF);
    @(posedge aclk);
    system_fault_in <= 1'b1;
    cyc(3);
    rchk("fault", `FIC_OFS_FAULT, 32'h0100);
    chk_bit("irq", 1'b0, irq);
    system_fault_in <= 1'b0;
    wr(`FIC_OFS_FMASK, 32'h0);
    chk_bit("irq", 1'b1, irq);
    wr(`FIC_OFS_FAULT, 32'h0100);
    rchk("fault", `FIC_OFS_FAULT, 32'h0);
    fic_far_i.cycle_kind(1'b1, 1'b0);
    bus_timeout_error_n <= 1'b0;
    cyc(2);
    rchk("fault", `FIC_OFS_FAULT, 32'h0400);
    fic_far_i.cycle_kind(1'b0, 1'b1);
    rchk("fault", `FIC_OFS_FAULT, 32'h0480);
    // Bit 10 is no longer set again by the cycle type, so only the input hold keeps it.
    wr(`FIC_OFS_FAULT, 32'h0400);
    rchk("fault", `FIC_OFS_FAULT, 32'h0480);
    bus_timeout_error_n <= 1'b1;
    memory_parity_error_in <= 1'b1;
    wr(`FIC_OFS_FAULT, 32'h0480);
    rchk("fault", `FIC_OFS_FAULT, 32'h2000);
    wr(`FIC_OFS_FAULT, 32'h2000);
    rchk("fault", `FIC_OFS_FAULT, 32'h2000);
    memory_parity_error_in <= 1'b0;
    rchk("fault", `FIC_OFS_FAULT, 32'h2000);
    wr(`FIC_OFS_FAULT, 32'h2000);
    for (int k = 0; k < 3; k++) begin
      fic_far_i.own(k != 1);
      fic_far_i.mmu_fault(2'(k), 3 + k);
      rchk("fault", `FIC_OFS_FAULT, (k == 1) ? 32'h4000 : 32'h8000);
      wr(`FIC_OFS_FAULT, 32'hC000);
      rchk("fault", `FIC_OFS_FAULT, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`FIC_OFS_IMASK, 32'(i % 2) << i);
      irq_n[i] <= 1'b0;
      cyc(2);
      irq_n[i] <= 1'b1;
      rchk("pending", `FIC_OFS_PEND, 32'h1 << i);
      chk_bit("irq", i % 2 == 0, irq);
      wr(`FIC_OFS_PEND, 32'h1 << i);
      rchk("pending", `FIC_OFS_PEND, 32'h0);
    end
    wr(`FIC_OFS_IMASK, 32'hFFFF);
    rchk("irq mask", `FIC_OFS_IMASK, 32'h00FF);
    power_fail_n <= 1'b0;
    cyc(2);
    rchk("pending", `FIC_OFS_PEND, 32'h8000);
    chk_bit("irq", 1'b1, irq);
    rchk("pins", `FIC_OFS_PINS, 32'h0050);
    wr(`FIC_OFS_PEND, 32'h8000);
    rchk("pending", `FIC_OFS_PEND, 32'h8000);
    power_fail_n <= 1'b1;
    irq_n[3] <= 1'b0;
    system_fault_in <= 1'b1;
    cyc(2);
    irq_n[3] <= 1'b1;
    system_fault_in <= 1'b0;
    rchk("pending", `FIC_OFS_PEND, 32'h8008);
    fic_far_i.mreset(1);
    rchk("pending", `FIC_OFS_PEND, 32'h0);
    rchk("fault", `FIC_OFS_FAULT, 32'h0);
    rchk("irq mask", `FIC_OFS_IMASK, 32'h00FF);
    core_write_in <= 1'b1;
    fic_far_i.own(1'b1);
    cyc(3);
    chk_word("driven address and data", 32'h1234BEEF, {oper_addr_o, oper_data_o});
    chk_word("bus enables", 32'h0, {30'h0, oper_addr_oe_n, oper_data_oe_n});
    test_mode_n <= 1'b0;
    cyc(3);
    chk_word("bus enables", 32'h3, {30'h0, oper_addr_oe_n, oper_data_oe_n});
    test_mode_n <= 1'b1;
    fic_far_i.own(1'b0);
    cyc(3);
    chk_word("bus enables", 32'h3, {30'h0, oper_addr_oe_n, oper_data_oe_n});
    chk_word("core read data", 32'hA55A, {16'h0, core_rdata});
    rchk("data in", `FIC_OFS_DATA_IN, 32'hA55A);
    rd(8'h18);
    chk_word("unmapped read", {30'h0, `FIC_RESP_SLVERR}, {30'h0, resp});
    wr(8'h02, 32'h0);
    chk_word("unaligned write", {30'h0, `FIC_RESP_SLVERR}, {30'h0, resp});
    wr(`FIC_OFS_PINS, 32'hFFFF);
    chk_word("read-only write", {30'h0, `FIC_RESP_OKAY}, {30'h0, resp});
    end_sim();
  end
endmodule : fic_top_test
